//--- pkg/awf_pkg.sv
`default_nettype none
package awf_pkg;
	// Default port widths and core storage (8192 words of 4 bits)
	localparam int unsigned AWF_WR_W_DEF = 4;
	localparam int unsigned AWF_RD_W_DEF = 4;
	localparam int unsigned AWF_CORE_BITS_DEF = 32768;
	// Separate-clock mode loses one unit to pointer hand-off
	localparam int unsigned AWF_SEP_LOSS = 1;
	// APB register offsets (byte addresses)
	localparam int unsigned AWF_PADDR_W = 8;
	localparam logic [7:0] AWF_CTRL_OFS = 8'h00;
	localparam logic [7:0] AWF_STAT_OFS = 8'h04;
	localparam logic [7:0] AWF_CAP_OFS = 8'h08;
	localparam logic [7:0] AWF_IST_OFS = 8'h0C;
	localparam logic [7:0] AWF_IMSK_OFS = 8'h10;
	// Control fields
	localparam int unsigned AWF_CTRL_W = 4;
	localparam logic [3:0] AWF_CTRL_RST = 4'h0;
	localparam int unsigned AWF_C_FALL_THROUGH = 0;
	localparam int unsigned AWF_C_REG_OUT = 1;
	localparam int unsigned AWF_C_ECC_PIPE = 2;
	localparam int unsigned AWF_C_SEP_CLK = 3;
	// Event bits, shared by status and mask
	localparam int unsigned AWF_EV_W = 4;
	localparam logic [3:0] AWF_IMSK_RST = 4'h0;
	localparam int unsigned AWF_EV_FULL = 0;
	localparam int unsigned AWF_EV_AVAIL = 1;
	localparam int unsigned AWF_EV_OVF = 2;
	localparam int unsigned AWF_EV_UNF = 3;
	// Status and capacity layout
	localparam int unsigned AWF_ST_EMPTY = 0;
	localparam int unsigned AWF_ST_FULL = 1;
	localparam int unsigned AWF_FIELD_W = 16;
	localparam int unsigned AWF_HI_LSB = 16;
endpackage
`default_nettype wire

//--- testbench/awf_fifo_test.sv
`default_nettype none
module awf_fifo_test import awf_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// Small core so full is reached quickly: 16 units of 4 bits
	localparam int unsigned WW = 4;
	localparam int unsigned RW = 8;
	localparam int unsigned CB = 64;
	logic core_clk, rstn, psel, penable, pwrite, pready, pslverr;
	logic [AWF_PADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, d32;
	logic wr_en, full, rd_en, rd_valid, empty, irq, v, er, ce;
	logic [WW-1:0] wr_data;
	logic [RW-1:0] rd_data, d;
	int n_mismatch = 0;
	int total_checks = 0;
	int cycles = 0;
	int u;
	awf_fifo #(.WR_W(WW), .RD_W(RW), .CORE_BITS(CB)) dut (
		.core_clk(core_clk), .rstn(rstn), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.wr_en(wr_en), .wr_data(wr_data), .full(full),
		.rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid), .empty(empty),
		.irq(irq)
	);
	awf_user_model #(.WR_W(WW), .RD_W(RW)) u_user (
		.core_clk(core_clk), .wr_en(wr_en), .wr_data(wr_data),
		.rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid)
	);
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			n_mismatch++;
			$display("unexpected at %0t: run timed out", $time);
			give_verdict();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Request held until the edge that samples pready high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic e);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] wd);
		apb(1'b1, a, wd, d32, er);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0, d32, er);
		chk({d32[31:1], d32[0] ^ er}, exp);
	endtask
	task automatic gap;
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
	endtask
	initial begin
		rstn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		repeat (10) @(posedge core_clk);
		rstn <= 1'b1;
		rchk(AWF_STAT_OFS, 32'h0000_0001);
		rchk(AWF_IMSK_OFS, 32'h0);
		for (int c = 0; c < 16; c++) begin
			u = CB / 4 + 2 * (c[0] + c[1] + c[2]) - c[3];
			wreg(AWF_CTRL_OFS, 32'(c));
			rchk(AWF_CTRL_OFS, 32'(c));
			rchk(AWF_CAP_OFS, {16'(u / 2), 16'(u)});
		end
		// Error stage alone, from the plain setting
		wreg(AWF_CTRL_OFS, 32'h0);
		wreg(AWF_CTRL_OFS, 32'h4);
		rchk(AWF_CAP_OFS, 32'h0009_0012);
		wreg(AWF_CTRL_OFS, 32'h0);
		u_user.push(4'h1);
		@(negedge core_clk);
		chk({31'h0, empty}, 32'h1);
		rchk(AWF_STAT_OFS, 32'h0001_0001);
		u_user.push(4'h2);
		@(negedge core_clk);
		chk({31'h0, empty}, 32'h0);
		u_user.pop(d, v);
		chk({23'h0, v, d}, 32'h0000_0121);
		rchk(AWF_IST_OFS, 32'h2);
		wreg(AWF_IMSK_OFS, 32'h1);
		for (int i = 0; i < 16; i++) begin
			u_user.push(4'(i));
		end
		gap();
		chk({30'h0, irq, full}, 32'h3);
		rchk(AWF_IST_OFS, 32'h3);
		gap();
		chk({31'h0, irq}, 32'h0);
		// Refused write leaves the fill alone
		u_user.push(4'hF);
		rchk(AWF_STAT_OFS, 32'h0010_0002);
		u_user.pop(d, v);
		chk({22'h0, full, v, d}, 32'h0000_0110);
		u_user.push(4'hA);
		@(negedge core_clk);
		chk({31'h0, full}, 32'h0);
		u_user.push(4'hB);
		@(negedge core_clk);
		chk({31'h0, full}, 32'h1);
		rchk(AWF_IST_OFS, 32'h5);
		for (int k = 1; k < 8; k++) begin
			u_user.pop(d, v);
			chk({23'h0, v, d}, {23'h0, 1'b1, 4'(2 * k + 1), 4'(2 * k)});
		end
		u_user.pop(d, v);
		chk({23'h0, v, d}, 32'h0000_01BA);
		u_user.pop(d, v);
		chk({30'h0, empty, v}, 32'h2);
		rchk(AWF_IST_OFS, 32'h8);
		// Fall-through: a lone narrow unit stays hidden until its partner arrives
		wreg(AWF_CTRL_OFS, 32'h1);
		u_user.push(4'h5);
		u_user.pop(d, v);
		chk({30'h0, empty, v}, 32'h2);
		u_user.push(4'h6);
		gap();
		chk({22'h0, empty, rd_valid, rd_data}, 32'h0000_0165);
		u_user.pop(d, v);
		chk({30'h0, empty, v}, 32'h2);
		// A write while the enable is low must leave no trace
		@(posedge core_clk);
		ce <= 1'b0;
		u_user.push(4'h7);
		ce <= 1'b1;
		rchk(AWF_STAT_OFS, 32'h0000_0001);
		apb(1'b0, 8'h20, 32'h0, d32, er);
		chk({er, d32[30:0]}, 32'h8000_0000);
		give_verdict();
	end
endmodule
`default_nettype wire

//--- testbench/awf_user_model.sv
`default_nettype none
module awf_user_model #(
	parameter int unsigned WR_W = 4,
	parameter int unsigned RD_W = 8
) (
	// Clock
	input wire logic core_clk,
	// Write side
	output logic wr_en,
	output logic [WR_W-1:0] wr_data,
	// Read side
	output logic rd_en,
	input wire logic [RD_W-1:0] rd_data,
	input wire logic rd_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		wr_en = 1'b0;
		wr_data = '0;
		rd_en = 1'b0;
	end
	// Inverted data after a write so a stale word never looks fresh
	task automatic push(input logic [WR_W-1:0] d);
		@(posedge core_clk);
		wr_en <= 1'b1;
		wr_data <= d;
		@(posedge core_clk);
		wr_en <= 1'b0;
		wr_data <= ~d;
	endtask
	// Data is sampled mid-cycle, right after the edge that took the pop, while rd_valid stands
	task automatic pop(output logic [RD_W-1:0] d, output logic v);
		@(posedge core_clk);
		rd_en <= 1'b1;
		@(posedge core_clk);
		rd_en <= 1'b0;
		@(negedge core_clk);
		d = rd_data;
		v = rd_valid;
	endtask
endmodule
`default_nettype wire

//--- verilog/awf_fifo.sv
`default_nettype none
module awf_fifo import awf_pkg::*; #(
	parameter int unsigned WR_W = AWF_WR_W_DEF,
	parameter int unsigned RD_W = AWF_RD_W_DEF,
	parameter int unsigned CORE_BITS = AWF_CORE_BITS_DEF
) (
	// Clock, reset, enable
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AWF_PADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Write port
	input wire logic wr_en,
	input wire logic [WR_W-1:0] wr_data,
	output logic full,
	// Read port
	input wire logic rd_en,
	output logic [RD_W-1:0] rd_data,
	output logic rd_valid,
	output logic empty,
	// Interrupt
	output logic irq
);
	localparam int unsigned UW = (WR_W < RD_W) ? WR_W : RD_W;
	localparam int unsigned WRU = WR_W / UW;
	localparam int unsigned RDU = RD_W / UW;
	localparam int unsigned CORE_U = CORE_BITS / UW;
	localparam int unsigned AW = $clog2(CORE_U + 3 * RDU);
	localparam int unsigned FW = AW + 1;
	localparam logic [FW-1:0] WRU_F = FW'(WRU);
	localparam logic [FW-1:0] RDU_F = FW'(RDU);
	localparam logic [FW-1:0] CORE_F = FW'(CORE_U);
	localparam logic [FW-1:0] LOSS_F = FW'(AWF_SEP_LOSS);

	function automatic logic [FW-1:0] depth_of(input logic [FW-1:0] cap,
			input logic [FW-1:0] per);
		return cap / per;
	endfunction

	// Register state
	logic [AWF_CTRL_W-1:0] ctrl_q, ctrl_d;
	logic [AWF_EV_W-1:0] imsk_q, imsk_d, ist_q, ist_d, ev;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d;
	// Queue state
	logic [FW-1:0] fill_q, fill_d, cap_units, wr_depth, rd_depth, left_after_pop;
	logic [AW-1:0] wptr_q, wptr_d, rptr_q, rptr_d, raddr;
	logic full_q, full_d, empty_q, empty_d, rvalid_q, rvalid_d, stage_v_q, stage_v_d;
	logic [RD_W-1:0] rdata_q, rdata_d, stage_q, stage_d, ram_word;
	logic push, pop, acc, fall_thru, reg_out;
	logic [1:0] stages;

	assign fall_thru = ctrl_q[AWF_C_FALL_THROUGH];
	assign reg_out = ctrl_q[AWF_C_REG_OUT];
	assign stages = 2'(fall_thru) + 2'(reg_out) + 2'(ctrl_q[AWF_C_ECC_PIPE]);

	// Each output stage holds one read word beyond the core
	always_comb begin
		cap_units = CORE_F + RDU_F * FW'(stages);
		if (ctrl_q[AWF_C_SEP_CLK]) begin
			cap_units = cap_units - LOSS_F;
		end
		wr_depth = depth_of(cap_units, WRU_F);
		rd_depth = depth_of(cap_units, RDU_F);
	end

	awf_unit_ram #(
		.UW(UW),
		.AW(AW),
		.WN(WRU),
		.RN(RDU)
	) u_ram (
		.core_clk(core_clk),
		.ce(ce),
		.we(push),
		.waddr(wptr_q),
		.wdata(wr_data),
		.raddr(raddr),
		.rdata(ram_word)
	);

	// Flags look only at registered state, so accept decisions never chase themselves
	assign push = wr_en && !full_q;
	assign pop = rd_en && !empty_q;

	always_comb begin
		fill_d = fill_q;
		if (push) begin
			fill_d = fill_d + WRU_F;
		end
		if (pop) begin
			fill_d = fill_d - RDU_F;
		end
		wptr_d = push ? wptr_q + AW'(WRU) : wptr_q;
		rptr_d = pop ? rptr_q + AW'(RDU) : rptr_q;
		left_after_pop = pop ? fill_q - RDU_F : fill_q;
		// Full as soon as a whole write word no longer fits, fragments included
		full_d = (fill_d + WRU_F) > cap_units;
		raddr = fall_thru ? rptr_d : rptr_q;
		stage_d = pop ? ram_word : stage_q;
		stage_v_d = pop && reg_out;
		rdata_d = rdata_q;
		if (fall_thru) begin
			// Shown word is counted in fill until taken; a write shows one cycle later
			rvalid_d = left_after_pop >= RDU_F;
			empty_d = !rvalid_d;
			if (rvalid_d) begin
				rdata_d = ram_word;
			end
		end else begin
			rvalid_d = reg_out ? stage_v_q : pop;
			empty_d = fill_d < RDU_F;
			if (rvalid_d) begin
				rdata_d = reg_out ? stage_q : ram_word;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			fill_q <= '0;
			wptr_q <= '0;
			rptr_q <= '0;
			full_q <= 1'b0;
			empty_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			stage_q <= '0;
			stage_v_q <= 1'b0;
		end else if (ce) begin
			fill_q <= fill_d;
			wptr_q <= wptr_d;
			rptr_q <= rptr_d;
			full_q <= full_d;
			empty_q <= empty_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			stage_q <= stage_d;
			stage_v_q <= stage_v_d;
		end
	end

	// APB: one wait state, so read data is registered before pready
	assign acc = psel && penable && pready_q;

	always_comb begin
		ev = '0;
		ev[AWF_EV_FULL] = full_d && !full_q;
		ev[AWF_EV_AVAIL] = !empty_d && empty_q;
		ev[AWF_EV_OVF] = wr_en && full_q;
		ev[AWF_EV_UNF] = rd_en && empty_q;
		pready_d = psel && penable && !pready_q;
		prdata_d = prdata_q;
		pslverr_d = 1'b0;
		ctrl_d = ctrl_q;
		imsk_d = imsk_q;
		ist_d = ist_q;
		if (pready_d) begin
			prdata_d = '0;
			case (paddr)
				AWF_CTRL_OFS: prdata_d[AWF_CTRL_W-1:0] = ctrl_q;
				AWF_STAT_OFS: begin
					prdata_d[AWF_ST_EMPTY] = empty_q;
					prdata_d[AWF_ST_FULL] = full_q;
					prdata_d[AWF_HI_LSB +: AWF_FIELD_W] = AWF_FIELD_W'(fill_q);
				end
				AWF_CAP_OFS: begin
					prdata_d[AWF_FIELD_W-1:0] = AWF_FIELD_W'(wr_depth);
					prdata_d[AWF_HI_LSB +: AWF_FIELD_W] = AWF_FIELD_W'(rd_depth);
				end
				AWF_IST_OFS: prdata_d[AWF_EV_W-1:0] = ist_q;
				AWF_IMSK_OFS: prdata_d[AWF_EV_W-1:0] = imsk_q;
				default: pslverr_d = 1'b1;
			endcase
		end
		if (acc && pwrite && paddr == AWF_CTRL_OFS) begin
			ctrl_d = pwdata[AWF_CTRL_W-1:0];
		end
		if (acc && pwrite && paddr == AWF_IMSK_OFS) begin
			imsk_d = pwdata[AWF_EV_W-1:0];
		end
		// Clear only what the read reported; a new event in the same cycle survives
		if (acc && !pwrite && paddr == AWF_IST_OFS) begin
			ist_d = ist_q & ~prdata_q[AWF_EV_W-1:0];
		end
		ist_d = ist_d | ev;
		irq_d = |(ist_d & imsk_d);
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q <= AWF_CTRL_RST;
			imsk_q <= AWF_IMSK_RST;
			ist_q <= '0;
			prdata_q <= '0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			irq_q <= 1'b0;
		end else if (ce) begin
			ctrl_q <= ctrl_d;
			imsk_q <= imsk_d;
			ist_q <= ist_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			irq_q <= irq_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign full = full_q;
	assign empty = empty_q;
	assign rd_data = rdata_q;
	assign rd_valid = rvalid_q;
	assign irq = irq_q;

	// Checking helpers: writes accepted since full last fell
	logic [1:0] wr_since_q;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			wr_since_q <= 2'h3;
		end else if (ce) begin
			if (full_q && !full_d) begin
				wr_since_q <= 2'h0;
			end else if (push && wr_since_q != 2'h3) begin
				wr_since_q <= wr_since_q + 2'h1;
			end
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	sequence full_wide_pop;
		ce && full_q && pop && !push;
	endsequence

	sequence sep_std_mode;
		ctrl_q[AWF_C_SEP_CLK] && stages == 2'h0;
	endsequence

	rd_depth_floor_a: assert property (
		int'(rd_depth) * int'(RDU) <= int'(cap_units)
		&& (int'(rd_depth) + 1) * int'(RDU) > int'(cap_units))
		else $error("read depth not rounded down");

	wr_depth_floor_a: assert property (
		int'(wr_depth) * int'(WRU) <= int'(cap_units)
		&& (int'(wr_depth) + 1) * int'(WRU) > int'(cap_units))
		else $error("write depth not rounded down");

	no_partial_read_a: assert property (
		(ce && rd_en && fill_q < RDU_F && !reg_out) |-> !pop ##1 !rd_valid)
		else $error("read granted without a whole word");

	full_clear_a: assert property (
		(WRU < RDU) throughout full_wide_pop |=> !full)
		else $error("full did not clear after one wide read");

	refill_two_a: assert property (
		(WRU < RDU && ce && full_d && !full_q) |-> wr_since_q >= 2'h1 || push
		&& wr_since_q != 2'h0)
		else $error("full returned after fewer than two writes");

	slot_free_a: assert property (
		(ce && push) |-> int'(fill_q) + int'(WRU) <= int'(cap_units))
		else $error("write accepted without a whole free slot");

	fill_track_a: assert property (
		ce |=> fill_q == $past(fill_q) + ($past(push) ? WRU_F : '0)
		- ($past(pop) ? RDU_F : '0))
		else $error("fill level does not follow traffic");

	flag_level_a: assert property (
		!full_q |-> fill_q + WRU_F <= cap_units)
		else $error("full flag disagrees with fill level");

	common_depth_a: assert property (
		(!ctrl_q[AWF_C_SEP_CLK] && !ctrl_q[AWF_C_ECC_PIPE])
		|-> rd_depth == FW'(CORE_U / RDU) + FW'(2'(fall_thru) + 2'(reg_out)))
		else $error("common-clock capacity wrong");

	sep_depth_a: assert property (
		sep_std_mode |-> cap_units == CORE_F - LOSS_F)
		else $error("separate-clock capacity wrong");

	ecc_depth_a: assert property (
		(ce && $rose(ctrl_q[AWF_C_ECC_PIPE]) && $stable(ctrl_q[AWF_C_SEP_CLK])
		&& $stable(stages - 2'(ctrl_q[AWF_C_ECC_PIPE])))
		|-> cap_units == $past(cap_units) + RDU_F)
		else $error("ecc stage did not add one read word");
endmodule
`default_nettype wire

//--- verilog/awf_unit_ram.sv
`default_nettype none
module awf_unit_ram #(
	parameter int unsigned UW = 4,
	parameter int unsigned AW = 14,
	parameter int unsigned WN = 1,
	parameter int unsigned RN = 1
) (
	// Clock and enable
	input wire logic core_clk,
	input wire logic ce,
	// Write side, WN units per word
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [WN*UW-1:0] wdata,
	// Read side, RN units per word, combinational
	input wire logic [AW-1:0] raddr,
	output logic [RN*UW-1:0] rdata
);
	// Storage in smallest-width units so both sides share one address space
	logic [UW-1:0] mem [0:(2**AW)-1];

	always_ff @(posedge core_clk) begin
		if (ce && we) begin
			for (int i = 0; i < WN; i++) begin
				mem[waddr + AW'(i)] <= wdata[i*UW +: UW];
			end
		end
	end

	always_comb begin
		for (int i = 0; i < RN; i++) begin
			rdata[i*UW +: UW] = mem[raddr + AW'(i)];
		end
	end
endmodule
`default_nettype wire
